// ---- gpio_cmd_regs.vh ----
/*
 Constants for the GPIO command controller: register offsets, field bits,
 command opcodes, pin configuration codes and flash image layout.
 Assumes inclusion by bare name from the design files.
*/
`ifndef GPIO_CMD_REGS_VH
`define GPIO_CMD_REGS_VH

// Register byte offsets
`define REG_OPCODE      8'h00
`define REG_PARAM_LO    8'h04
`define REG_PARAM_HI    8'h08
`define REG_RESP_LO     8'h0C
`define REG_RESP_HI     8'h10
`define REG_STATUS      8'h14
`define REG_INT_STATUS  8'h18
`define REG_INT_MASK    8'h1C

// Status / interrupt bit positions
`define BIT_CMD_ERR     0
`define BIT_CMD_DONE    1
`define BIT_BOOT_DONE   2
`define INT_WIDTH       3

// Command opcodes
`define OP_CFG_WRITE    8'h23
`define OP_CFG_READ     8'h24
`define OP_OUT_WRITE    8'h25
`define OP_OUT_READ     8'h26
`define OP_RSV_READ     8'h27

// Two-bit pin configuration codes
`define CFG_ALT         2'h0
`define CFG_KEEP        2'h0
`define CFG_INPUT       2'h1
`define CFG_PUSH_PULL   2'h2
`define CFG_OPEN_DRAIN  2'h3

// Flash image word indices
`define FL_CFG_LO       2'h0
`define FL_CFG_HI       2'h1
`define FL_RESERVED     2'h2
`define FL_OUT_VAL      2'h3
`define FL_WORDS        3'h4

// Reset values
`define RST_WORD        32'h0000_0000
`define RST_CFG         64'h0000_0000_0000_0000

`endif

// ---- flash_defaults_loader.v ----
/*
 Startup loader: reads the default pin image word by word from external flash.
 Assumes a flash read port that answers each one-cycle read strobe with a
 one-cycle valid carrying the word, after any latency.
*/
`timescale 1ns/1ps
`include "gpio_cmd_regs.vh"

module flash_defaults_loader #(
  parameter [23:0] FLASH_BASE = 24'h00_0000
) (
  input  wire        mclk,
  input  wire        arst_n,
  output reg         flash_rd_r,
  output reg  [23:0] flash_addr_r,
  input  wire [31:0] flash_rdata,
  input  wire        flash_rvalid,
  output reg  [31:0] word_r,
  output reg  [1:0]  word_idx_r,
  output reg         word_vld_r,
  output reg         done_r
);

  localparam [1:0] ST_ISSUE = 2'd0;
  localparam [1:0] ST_WAIT  = 2'd1;
  localparam [1:0] ST_DONE  = 2'd2;

  reg [1:0] state_r;
  reg [2:0] cnt_r;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_r      <= ST_ISSUE;
      cnt_r        <= 3'h0;
      flash_rd_r   <= 1'b0;
      flash_addr_r <= 24'h00_0000;
      word_r       <= `RST_WORD;
      word_idx_r   <= 2'h0;
      word_vld_r   <= 1'b0;
      done_r       <= 1'b0;
    end else begin
      flash_rd_r <= 1'b0;
      word_vld_r <= 1'b0;
      case (state_r)
        ST_ISSUE: begin
          flash_rd_r   <= 1'b1;
          flash_addr_r <= FLASH_BASE + {19'h0_0000, cnt_r, 2'b00};
          state_r      <= ST_WAIT;
        end
        ST_WAIT: begin
          if (flash_rvalid) begin
            word_r     <= flash_rdata;
            word_idx_r <= cnt_r[1:0];
            word_vld_r <= 1'b1;
            cnt_r      <= cnt_r + 3'h1;
            if (cnt_r == `FL_WORDS - 3'h1)
              state_r <= ST_DONE;
            else
              state_r <= ST_ISSUE;
          end
        end
        ST_DONE: begin
          // Done rises one cycle after the last word so it is already applied
          done_r <= 1'b1;
        end
        default: state_r <= ST_DONE;
      endcase
    end
  end

endmodule // flash_defaults_loader

// ---- gpio_command_control.v ----
/*
 GPIO command controller for a 32-pin bank: command execution over a plain
 register port, pin drive logic, sticky error, interrupts, flash defaults.
 Register map: opcode, two parameter words, two response words, status,
 interrupt status (write one to clear) and interrupt mask.
 A command runs when its opcode is written; parameters must be in place first.
 Assumes pin inputs synchronous to mclk and a pad that resolves out/oe.
 Assumes the host waits for the boot flag; earlier opcodes are dropped.
*/
// Local design decisions: the address map and the address-and-strobe port.
// What this block does
// R1 - Configuration read returns eight bytes, two bits per pin, pin 0 lowest.
// R2 - Returned codes: 0 alternative, 1 input, 2 push-pull, 3 open-drain.
// R3 - Host sends output write as four mask bytes then four value bytes.
// R4 - Masked pins take the value bit; unmasked pins keep their output.
// R5 - Mask on any reserved pin flags error and applies nothing.
// R6 - Value written to an input pin is held until it becomes output.
// R7 - Bytes little-endian: first byte bit 0 is pin 0, fourth bit 7 pin 31.
// R8 - Value zero drives low; value one drives high in push-pull and leaves an open-drain pin undriven.
// R9 - Output read returns four bytes of current pin levels.
// R10 - Reserved read returns four-byte bitmap, one marks device-reserved pins.
// R11 - Flash defaults loaded and applied before host commands take effect.
// R12 - Configuration write: 0 keeps, 1 input, 2 push-pull, 3 open-drain.
// R13 - Non-zero code on reserved pin flags error and sets nothing.
// R14 - Sticky command error readable by host, cleared when read.
`timescale 1ns/1ps
`include "gpio_cmd_regs.vh"

module gpio_command_control #(
  parameter integer  NPINS      = 32,
  parameter [23:0]   FLASH_BASE = 24'h00_0000
) (
  input  wire             mclk,
  input  wire             arst_n,
  input  wire [7:0]       addr,
  input  wire [31:0]      wdata,
  input  wire             wr_stb,
  input  wire             rd_stb,
  output reg  [31:0]      rdata_r,
  output reg              irq_r,
  input  wire [NPINS-1:0] gpio_in,
  output reg  [NPINS-1:0] gpio_out_r,
  output reg  [NPINS-1:0] gpio_oe_r,
  output wire             flash_rd_r,
  output wire [23:0]      flash_addr_r,
  input  wire [31:0]      flash_rdata,
  input  wire             flash_rvalid
);

  // Width of one pin's configuration code
  localparam integer CODE_W = 2;

  // Per-pin merge of a configuration write; code 0 keeps the old code
  function [2*NPINS-1:0] cfg_merge;
    input [2*NPINS-1:0] old_cfg;
    input [2*NPINS-1:0] new_cfg;
    integer i;
    begin
      cfg_merge = old_cfg;
      for (i = 0; i < NPINS; i = i + 1) begin
        if (new_cfg[CODE_W*i +: CODE_W] != `CFG_KEEP)
          cfg_merge[CODE_W*i +: CODE_W] = new_cfg[CODE_W*i +: CODE_W];
      end
    end
  endfunction

  // One bit per pin: code is not "keep"
  function [NPINS-1:0] cfg_touched;
    input [2*NPINS-1:0] new_cfg;
    integer i;
    begin
      cfg_touched = {NPINS{1'b0}};
      for (i = 0; i < NPINS; i = i + 1)
        cfg_touched[i] = (new_cfg[CODE_W*i +: CODE_W] != `CFG_KEEP);
    end
  endfunction

  reg  [2*NPINS-1:0] cfg_r;
  reg  [NPINS-1:0]   rsv_r;
  reg  [NPINS-1:0]   val_r;
  reg  [31:0]        param_lo_r;
  reg  [31:0]        param_hi_r;
  reg  [31:0]        resp_lo_r;
  reg  [31:0]        resp_hi_r;
  reg                err_r;
  reg  [`INT_WIDTH-1:0] int_status_r;
  reg  [`INT_WIDTH-1:0] int_mask_r;

  reg  [2*NPINS-1:0] cfg_nxt;
  reg  [NPINS-1:0]   rsv_nxt;
  reg  [NPINS-1:0]   val_nxt;
  reg  [31:0]        resp_lo_nxt;
  reg  [31:0]        resp_hi_nxt;
  reg                err_nxt;
  reg  [`INT_WIDTH-1:0] int_status_nxt;
  reg  [`INT_WIDTH-1:0] ev;
  reg  [NPINS-1:0]   out_nxt;
  reg  [NPINS-1:0]   oe_nxt;
  reg  [31:0]        rdata_nxt;
  reg  [31:0]        param_lo_nxt;
  reg  [31:0]        param_hi_nxt;
  reg  [`INT_WIDTH-1:0] int_mask_nxt;

  wire [31:0] ld_word;
  wire [1:0]  ld_idx;
  wire        ld_vld;
  wire        boot_done;
  reg         boot_done_d_r;

  flash_defaults_loader #(
    .FLASH_BASE (FLASH_BASE)
  ) u_loader (
    .mclk         (mclk),
    .arst_n       (arst_n),
    .flash_rd_r   (flash_rd_r),
    .flash_addr_r (flash_addr_r),
    .flash_rdata  (flash_rdata),
    .flash_rvalid (flash_rvalid),
    .word_r       (ld_word),
    .word_idx_r   (ld_idx),
    .word_vld_r   (ld_vld),
    .done_r       (boot_done)
  );

  wire op_wr  = wr_stb && (addr == `REG_OPCODE);
  wire [7:0] opcode = wdata[7:0];
  // Commands are ignored until the flash image is in place
  wire cmd_go = op_wr && boot_done; // R11

  // Reserved pins touched by the pending command; any one makes it an error
  wire [NPINS-1:0] rsv_hit_out = param_lo_r[NPINS-1:0] & rsv_r;
  wire [NPINS-1:0] rsv_hit_cfg = cfg_touched({param_hi_r, param_lo_r}) & rsv_r;

  // Command execution and flash load
  always @* begin
    cfg_nxt     = cfg_r;
    rsv_nxt     = rsv_r;
    val_nxt     = val_r;
    resp_lo_nxt = resp_lo_r;
    resp_hi_nxt = resp_hi_r;
    ev          = {`INT_WIDTH{1'b0}};
    // Flash words land one at a time; the last one lifts the command gate
    if (ld_vld) begin
      case (ld_idx) // R11
        `FL_CFG_LO:   cfg_nxt[31:0]  = ld_word;
        `FL_CFG_HI:   cfg_nxt[63:32] = ld_word;
        `FL_RESERVED: rsv_nxt        = ld_word;
        `FL_OUT_VAL:  val_nxt        = ld_word;
        default:      rsv_nxt        = rsv_r;
      endcase
    end
    if (boot_done && !boot_done_d_r)
      ev[`BIT_BOOT_DONE] = 1'b1;
    if (cmd_go) begin
      ev[`BIT_CMD_DONE] = 1'b1;
      case (opcode)
        `OP_CFG_READ: begin
          // Pin i sits at bits 2i+1:2i, byte 1 in the low lane
          resp_lo_nxt = cfg_r[31:0]; // R1 R2
          resp_hi_nxt = cfg_r[63:32]; // R1
        end
        `OP_CFG_WRITE: begin
          // A single touched reserved pin rejects the whole write
          if (|rsv_hit_cfg)
            ev[`BIT_CMD_ERR] = 1'b1; // R13
          else
            cfg_nxt = cfg_merge(cfg_r, {param_hi_r, param_lo_r}); // R12
        end
        `OP_OUT_WRITE: begin
          // Mask in the low word, values in the high word, pin 0 at bit 0
          if (|rsv_hit_out)
            ev[`BIT_CMD_ERR] = 1'b1; // R5
          else
            val_nxt = (val_r & ~param_lo_r) | (param_hi_r & param_lo_r); // R3 R4 R7
        end
        `OP_OUT_READ: begin
          // Pins are sampled at the opcode edge, not when the word is read
          resp_lo_nxt = gpio_in; // R9
          resp_hi_nxt = `RST_WORD;
        end
        `OP_RSV_READ: begin
          resp_lo_nxt = rsv_r; // R10
          resp_hi_nxt = `RST_WORD;
        end
        default: ev[`BIT_CMD_ERR] = 1'b1;
      endcase
    end
  end

  // Pin drive follows the stored value only for output codes
  always @* begin : drive
    integer i;
    out_nxt = {NPINS{1'b0}};
    oe_nxt  = {NPINS{1'b0}};
    for (i = 0; i < NPINS; i = i + 1) begin
      case (cfg_nxt[CODE_W*i +: CODE_W])
        `CFG_PUSH_PULL: begin
          out_nxt[i] = val_nxt[i]; // R8
          oe_nxt[i]  = 1'b1;
        end
        `CFG_OPEN_DRAIN: begin
          // Only the low level is driven; high is left to the pull-up
          out_nxt[i] = 1'b0; // R8
          oe_nxt[i]  = ~val_nxt[i];
        end
        `CFG_INPUT: begin
          // Value stays pending in val_r until the pin turns output
          out_nxt[i] = 1'b0; // R6
          oe_nxt[i]  = 1'b0;
        end
        default: begin
          // Alternative function owns the pad; keep off it
          out_nxt[i] = 1'b0;
          oe_nxt[i]  = 1'b0;
        end
      endcase
    end
  end

  wire status_rd = rd_stb && (addr == `REG_STATUS);
  wire ints_w1c  = wr_stb && (addr == `REG_INT_STATUS);

  // Sticky flags: a new event beats a clear in the same cycle
  always @* begin
    err_nxt = err_r;
    if (status_rd)
      err_nxt = 1'b0; // R14
    if (ev[`BIT_CMD_ERR])
      err_nxt = 1'b1; // R14
    int_status_nxt = int_status_r;
    if (ints_w1c)
      int_status_nxt = int_status_r & ~wdata[`INT_WIDTH-1:0];
    int_status_nxt = int_status_nxt | ev;
  end

  // Host-written parameter and mask registers
  always @* begin
    param_lo_nxt = param_lo_r;
    param_hi_nxt = param_hi_r;
    int_mask_nxt = int_mask_r;
    if (wr_stb) begin
      case (addr)
        `REG_PARAM_LO: param_lo_nxt = wdata;
        `REG_PARAM_HI: param_hi_nxt = wdata;
        `REG_INT_MASK: int_mask_nxt = wdata[`INT_WIDTH-1:0];
        default:       param_lo_nxt = param_lo_r;
      endcase
    end
  end

  // Read data, valid only in the cycle after the strobe
  always @* begin
    rdata_nxt = `RST_WORD;
    if (rd_stb) begin
      case (addr)
        `REG_PARAM_LO:   rdata_nxt = param_lo_r;
        `REG_PARAM_HI:   rdata_nxt = param_hi_r;
        `REG_RESP_LO:    rdata_nxt = resp_lo_r;
        `REG_RESP_HI:    rdata_nxt = resp_hi_r;
        `REG_STATUS: begin
          rdata_nxt[`BIT_CMD_ERR]   = err_r; // R14
          rdata_nxt[`BIT_BOOT_DONE] = boot_done;
        end
        `REG_INT_STATUS: rdata_nxt[`INT_WIDTH-1:0] = int_status_r;
        `REG_INT_MASK:   rdata_nxt[`INT_WIDTH-1:0] = int_mask_r;
        default:         rdata_nxt = `RST_WORD;
      endcase
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r         <= `RST_CFG;
      rsv_r         <= `RST_WORD;
      val_r         <= `RST_WORD;
      param_lo_r    <= `RST_WORD;
      param_hi_r    <= `RST_WORD;
      resp_lo_r     <= `RST_WORD;
      resp_hi_r     <= `RST_WORD;
      err_r         <= 1'b0;
      int_status_r  <= {`INT_WIDTH{1'b0}};
      int_mask_r    <= {`INT_WIDTH{1'b0}};
      boot_done_d_r <= 1'b0;
      rdata_r       <= `RST_WORD;
      irq_r         <= 1'b0;
      gpio_out_r    <= `RST_WORD;
      gpio_oe_r     <= `RST_WORD;
    end else begin
      cfg_r         <= cfg_nxt;
      rsv_r         <= rsv_nxt;
      val_r         <= val_nxt;
      resp_lo_r     <= resp_lo_nxt;
      resp_hi_r     <= resp_hi_nxt;
      err_r         <= err_nxt;
      int_status_r  <= int_status_nxt;
      boot_done_d_r <= boot_done;
      rdata_r       <= rdata_nxt;
      param_lo_r    <= param_lo_nxt;
      param_hi_r    <= param_hi_nxt;
      int_mask_r    <= int_mask_nxt;
      // Next mask, so a mask write shows on the pin at once
      irq_r         <= |(int_status_nxt & int_mask_nxt);
      gpio_out_r    <= out_nxt;
      gpio_oe_r     <= oe_nxt;
    end
  end

endmodule // gpio_command_control

// ---- gpio_cmd_props.sv ----
/* Port checker for gpio_command_control.
   Assumes one clock, async active-low reset, host waits for boot. */
`timescale 1ns/1ps
module gpio_cmd_props #(
  parameter integer NPINS      = 32,
  parameter [23:0]  FLASH_BASE = 24'h00_0000
) (
  input wire logic             mclk,
  input wire logic             arst_n,
  input wire logic [7:0]       addr,
  input wire logic [31:0]      wdata,
  input wire logic             wr_stb,
  input wire logic             rd_stb,
  input wire logic [31:0]      rdata_r,
  input wire logic             irq_r,
  input wire logic [NPINS-1:0] gpio_in,
  input wire logic [NPINS-1:0] gpio_out_r,
  input wire logic [NPINS-1:0] gpio_oe_r,
  input wire logic             flash_rd_r,
  input wire logic [23:0]      flash_addr_r,
  input wire logic [31:0]      flash_rdata,
  input wire logic             flash_rvalid
);
  logic [2:0] rv_cnt_r;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)
      rv_cnt_r <= 3'h0;
    else if (flash_rvalid && rv_cnt_r != 3'h4)
      rv_cnt_r <= rv_cnt_r + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_op(logic [7:0] op);
    wr_stb && addr == 8'h00 && wdata[7:0] == op;
  endsequence
  // Margin covers word apply plus boot flag delay
  sequence s_ready;
    $past(rv_cnt_r, 8) == 3'h4;
  endsequence
  AST_OD_LOW: assert property ((gpio_out_r & ~gpio_oe_r) == '0) else $error("pin high while undriven");
  // Loader takes the word on one edge and raises the next strobe on the following one
  AST_FLASH_NEXT: assert property (flash_rvalid && rv_cnt_r < 3'h3 |-> ##2
    flash_rd_r && flash_addr_r == FLASH_BASE + {19'h0, rv_cnt_r, 2'h0}) else $error("flash read order");
  AST_FLASH_STOP: assert property (rv_cnt_r == 3'h4 |-> !flash_rd_r) else $error("extra flash read");
  AST_PINS_HOLD: assert property (s_ready ##0 !$past(wr_stb && addr == 8'h00) |->
    $stable(gpio_out_r) && $stable(gpio_oe_r)) else $error("pins moved without command");
  AST_MASK_OFF: assert property (wr_stb && addr == 8'h1C && wdata[2:0] == 3'h0 |-> ##2 !irq_r)
    else $error("irq with mask clear");
  AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata_r == 32'h0) else $error("rdata not idle");
  AST_UNMAPPED: assert property (rd_stb && addr > 8'h1C |=> rdata_r == 32'h0) else $error("unmapped read");
  AST_RSV_HI: assert property (s_ready ##0 s_op(8'h27) ##2 (rd_stb && addr == 8'h10) |=> rdata_r == 32'h0)
    else $error("reserved upper word");
  AST_OUT_READ: assert property (s_ready ##0 s_op(8'h26) ##2 (rd_stb && addr == 8'h0C) |=>
    rdata_r == $past(gpio_in, 3)) else $error("pin level read");
endmodule // gpio_cmd_props
bind gpio_command_control gpio_cmd_props #(.NPINS(NPINS), .FLASH_BASE(FLASH_BASE)) u_props (
  .mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata_r(rdata_r), .irq_r(irq_r), .gpio_in(gpio_in), .gpio_out_r(gpio_out_r), .gpio_oe_r(gpio_oe_r),
  .flash_rd_r(flash_rd_r), .flash_addr_r(flash_addr_r), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));

// ---- flash_model.sv ----
/* Behavioural flash holding the four-word default pin image.
   Assumes one read in flight and a base address of zero. */
`timescale 1ns/1ps
module flash_model #(
  parameter integer LAT = 3
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        rd,
  input  wire logic [23:0] addr,
  output logic      [31:0] rdata,
  output logic             rvalid
);
  logic [31:0] img [4];
  logic [3:0]  wait_r;
  logic [1:0]  idx_r;
  initial img = '{32'h5555_AAAA, 32'h0000_FFFF, 32'hFF00_0000, 32'h0000_00F0};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wait_r <= 4'h0;
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
    end else begin
      rvalid <= wait_r == 4'h1;
      // Data toggles when idle so a stale word never passes
      rdata <= (wait_r == 4'h1) ? img[idx_r] : ~rdata;
      if (rd) begin
        wait_r <= 4'(LAT);
        idx_r  <= addr[3:2];
      end else if (wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
    end
  end
endmodule // flash_model

// ---- tb_gpio_command_control.sv ----
/* Self-checking bench for gpio_command_control.
   Assumes the flash image of flash_model; pin inputs are set by the scenarios. */
`timescale 1ns/1ps
module tb_gpio_command_control;
  logic        mclk = 0, arst_n = 0, wr_stb = 0, rd_stb = 0, irq_r, flash_rd_r, flash_rvalid;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata_r, gpio_out_r, gpio_oe_r, flash_rdata, d;
  logic [31:0] gpio_in = 32'hA5A5_5A5A;
  logic [23:0] flash_addr_r;
  int          fail_count = 0, num_checks = 0;
  always #5 mclk = ~mclk;
  gpio_command_control uut (.mclk(mclk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata_r(rdata_r), .irq_r(irq_r), .gpio_in(gpio_in), .gpio_out_r(gpio_out_r),
    .gpio_oe_r(gpio_oe_r), .flash_rd_r(flash_rd_r), .flash_addr_r(flash_addr_r),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
  flash_model u_flash (.mclk(mclk), .arst_n(arst_n), .rd(flash_rd_r), .addr(flash_addr_r),
    .rdata(flash_rdata), .rvalid(flash_rvalid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata_r;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // Mask word first, then value word, then the opcode
  task automatic cmd(input logic [7:0] op, input logic [31:0] lo, input logic [31:0] hi);
    wr(8'h04, lo);
    wr(8'h08, hi);
    wr(8'h00, {24'h0, op});
  endtask
  task automatic pins(input logic [31:0] out, input logic [31:0] oe);
    @(posedge mclk);
    #1 chk(gpio_out_r, out);
    chk(gpio_oe_r, oe);
  endtask
  task automatic t_boot;
    // Unknown opcode before boot must leave no trace
    cmd(8'h3F, 32'h0, 32'h0);
    d = 32'h0;
    for (int i = 0; i < 60 && d[2] !== 1'b1; i++)
      rd(8'h14);
    chk(d, 32'h0000_0004);
    rdchk(8'h18, 32'h0000_0004);
    pins(32'h0000_00F0, 32'h00FF_00FF);
    cmd(8'h24, 32'h0, 32'h0);
    rdchk(8'h0C, 32'h5555_AAAA);
    rdchk(8'h10, 32'h0000_FFFF);
    cmd(8'h27, 32'h0, 32'h0);
    rdchk(8'h10, 32'h0000_0000);
    rdchk(8'h0C, 32'hFF00_0000);
  endtask
  task automatic t_outw;
    cmd(8'h25, 32'h0001_010F, 32'h0001_0105);
    pins(32'h0000_00F5, 32'h00FE_00FF);
    rdchk(8'h08, 32'h0001_0105);
    cmd(8'h23, 32'h0002_0000, 32'h0);
    pins(32'h0000_01F5, 32'h00FE_01FF);
    cmd(8'h24, 32'h0, 32'h0);
    rdchk(8'h0C, 32'h5556_AAAA);
  endtask
  task automatic t_err;
    cmd(8'h25, 32'h8000_0001, 32'h0);
    pins(32'h0000_01F5, 32'h00FE_01FF);
    rdchk(8'h14, 32'h0000_0005);
    rdchk(8'h14, 32'h0000_0004);
    cmd(8'h23, 32'h0, 32'h0001_0004);
    pins(32'h0000_01F5, 32'h00FE_01FF);
    rdchk(8'h14, 32'h0000_0005);
    cmd(8'h3F, 32'h0, 32'h0);
    rdchk(8'h14, 32'h0000_0005);
  endtask
  task automatic t_irq;
    wr(8'h1C, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, irq_r}, 32'h1);
    rdchk(8'h1C, 32'h0000_0001);
    wr(8'h18, 32'h1);
    repeat (2) @(posedge mclk);
    #1 chk({31'h0, irq_r}, 32'h0);
    rdchk(8'h18, 32'h0000_0006);
    wr(8'h1C, 32'h0);
    rdchk(8'h20, 32'h0);
  endtask
  task automatic t_outr;
    @(posedge mclk);
    gpio_in <= 32'h0F1E_2D3C;
    cmd(8'h26, 32'h0, 32'h0);
    rdchk(8'h0C, 32'h0F1E_2D3C);
    rdchk(8'h10, 32'h0);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_boot();
    t_outw();
    t_err();
    t_irq();
    t_outr();
    conclude();
  end
  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    conclude();
  end
endmodule // tb_gpio_command_control
